/* File: rtl/prp_cfg.svh */
// Purpose: offsets, field positions, reset values and codes of the pseudo-random pwm channel
// Assumes: byte offsets on a 32-bit wishbone bus
// Notes: definitions only
`ifndef PRP_CFG_SVH
`define PRP_CFG_SVH

// ==========================================
// register offsets
`define PRP_OFF_ENABLE 8'h00
`define PRP_OFF_SWEVT 8'h04
`define PRP_OFF_SOURCE 8'h08
`define PRP_OFF_CONFIG 8'h0c
`define PRP_OFF_STATUS 8'h10
`define PRP_OFF_COUNTER 8'h14
`define PRP_OFF_COMPARE 8'h18
`define PRP_OFF_COMPARE_SH 8'h1c
`define PRP_OFF_PERIOD 8'h20
`define PRP_OFF_PERIOD_SH 8'h24
`define PRP_OFF_TRIG_SRC 8'h28
`define PRP_OFF_TRIG_EDGE 8'h2c
`define PRP_OFF_OUT_ACT 8'h30
`define PRP_OFF_IRQ_REQ 8'h34
`define PRP_OFF_IRQ_FORCE 8'h38
`define PRP_OFF_IRQ_MASK 8'h3c
`define PRP_OFF_IRQ_GATED 8'h40

// ==========================================
// counter_config_reg fields
`define PRP_CFG_SWAP_CC 0
`define PRP_CFG_SWAP_PER 1
`define PRP_CFG_ONE_SHOT 2
`define PRP_CFG_HALT_KILL 3
`define PRP_CFG_SYNC_KILL 4
`define PRP_CFG_MODE_LO 24
`define PRP_CFG_MODE_HI 26
`define PRP_CFG_MASK 32'h0700_001f
`define PRP_MODE_PRPWM 3'h6

// ==========================================
// other fields and reset values
`define PRP_IRQ_TC 0
`define PRP_IRQ_CC 1
`define PRP_ACT_CC_LO 0
`define PRP_RST_CONFIG 32'h0000_0000
`define PRP_RST_WORD16 16'h0000
`define PRP_RST_TRIG_EDGE 8'h00
`define PRP_RST_OUT_ACT 6'h3f
`define PRP_START_SEED 16'h0001
`define PRP_NTRIG 15

`endif

/* File: rtl/prp_pkg.sv */
// Purpose: types of the pseudo-random pwm channel
// Assumes: used with prp_cfg.svh
// Notes: nothing is imported, every use is scoped
package prp_pkg;

	// ==========================================
	// channel events, reload in bit 0
	typedef struct packed {
		logic sw;
		logic kill;
		logic start;
		logic reload;
	} prp_evt_t;

	typedef enum logic [1:0] {
		PRP_RISE = 2'h0,
		PRP_FALL = 2'h1,
		PRP_BOTH = 2'h2,
		PRP_PASS = 2'h3
	} prp_edge_t;

	typedef enum logic [1:0] {
		PRP_IDLE = 2'h1,
		PRP_RUN = 2'h2
	} prp_state_t;

	typedef enum logic [1:0] {
		PRP_SET = 2'h0,
		PRP_CLEAR = 2'h1,
		PRP_INVERT = 2'h2,
		PRP_KEEP = 2'h3
	} prp_act_t;

endpackage

/* File: rtl/prp_edge.sv */
// Purpose: edge detector for one trigger input
// Assumes: input already synchronised to clk
// Notes: pass mode forwards the level
module prp_edge (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sig,
	input wire prp_pkg::prp_edge_t mode,
	output logic evt
);
	logic prev;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			prev <= 1'b0;
		else
			prev <= sig;
	end

	always_comb
	begin
		case (mode)
			prp_pkg::PRP_RISE: evt = sig & ~prev;
			prp_pkg::PRP_FALL: evt = ~sig & prev;
			prp_pkg::PRP_BOTH: evt = sig ^ prev;
			default: evt = sig;
		endcase
	end
endmodule

/* File: rtl/prp_top.sv */
// Purpose: one timer channel in pseudo-random pwm mode, wishbone register slave
// Assumes: single clock CLK_SYS, counter steps once per clock while running
// Notes: trigger pins pass two flip-flops before the edge detectors
// How it works
// - counter steps as lfsr with taps x^16 + x^14 + x^13 + x^11 + 1
// - any non-zero seed walks all values 1 to 0xffff before repeating
// - line high while counter bits 14..0 below the 16-bit compare value
// - compare 0x8000 or more gives constant high, zero gives constant low
// - reload starts the counter like start but keeps the counter value
// - terminal count when counter equals period
// - at terminal count a pending switch swaps compare and period pairs if enabled
// - switch taken on chosen edge and held pending until terminal count
// - a kill event may stop the counter per kill configuration
// - one-shot stops the counter by hardware at terminal count
// - no wrap-high, wrap-low or trigger-condition events in this mode
// - compare match only while running and counter equals compare
// - mode value 110 in config bits 26..24 selects this mode
// - period, shadow period, compare and shadow compare are 16 bits
// - source and edge select per reload, start, kill and switch input
// - output lines set, cleared or inverted on compare match per action register bits 1..0
// - request register latches terminal count and compare match
// - force register sets request bits
// - gated view is request and enable bits
// - source register shows this channel raised the combined interrupt
// - halt-on-kill stops counter too, otherwise only outputs blocked
// - synchronous kill blocks outputs until next terminal count
// - asynchronous kill blocks outputs only while kill input present
`include "prp_cfg.svh"

module prp_top (
	input wire logic CLK_SYS,
	input wire logic RSTN,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:2] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic [`PRP_NTRIG-1:0] TRIG_IN,
	output logic LINE_OUT,
	output logic LINE_OUT_COMPL,
	output logic IRQ_OUT
);
	// ==========================================
	// state
	logic enabled;
	logic [31:0] config_q;
	logic [15:0] counter;
	logic [15:0] compare;
	logic [15:0] compare_sh;
	logic [15:0] period;
	logic [15:0] period_sh;
	logic [15:0] trig_src;
	logic [7:0] trig_edge;
	logic [5:0] out_act;
	logic [1:0] irq_req;
	logic [1:0] irq_mask;
	logic sw_pending;
	logic kill_hold;
	prp_pkg::prp_state_t state;
	prp_pkg::prp_state_t next_state;
	prp_pkg::prp_evt_t sw_cmd;
	prp_pkg::prp_evt_t hw_evt;
	prp_pkg::prp_evt_t ev;
	logic [`PRP_NTRIG-1:0] sync1;
	logic [`PRP_NTRIG-1:0] sync2;
	logic [15:0] src;

	// ==========================================
	// wishbone decode
	logic req;
	logic wr;
	logic [7:0] addr;
	logic [31:0] rdata;

	assign req = WB_CYC_I & WB_STB_I;
	assign wr = req & WB_ACK_O & WB_WE_I;
	assign addr = {WB_ADR_I, 2'h0};

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				r[8*i+:8] = d[8*i+:8];
		return r;
	endfunction

	function automatic logic wr_at(input logic w, input logic [7:0] a, input logic [7:0] off);
		return w && (a == off);
	endfunction

	logic [31:0] wd_cfg;
	logic [31:0] wd_cnt;
	logic [31:0] wd_cmp;
	logic [31:0] wd_cmps;
	logic [31:0] wd_per;
	logic [31:0] wd_pers;
	logic [31:0] wd_src;
	logic [31:0] wd_edge;
	logic [31:0] wd_act;
	logic [31:0] wd_sw;

	assign wd_cfg = wmerge(config_q, WB_DAT_I, WB_SEL_I) & `PRP_CFG_MASK;
	assign wd_cnt = wmerge({16'h0000, counter}, WB_DAT_I, WB_SEL_I);
	assign wd_cmp = wmerge({16'h0000, compare}, WB_DAT_I, WB_SEL_I);
	assign wd_cmps = wmerge({16'h0000, compare_sh}, WB_DAT_I, WB_SEL_I);
	assign wd_per = wmerge({16'h0000, period}, WB_DAT_I, WB_SEL_I);
	assign wd_pers = wmerge({16'h0000, period_sh}, WB_DAT_I, WB_SEL_I);
	assign wd_src = wmerge({16'h0000, trig_src}, WB_DAT_I, WB_SEL_I);
	assign wd_edge = wmerge({24'h000000, trig_edge}, WB_DAT_I, WB_SEL_I);
	assign wd_act = wmerge({26'h0000000, out_act}, WB_DAT_I, WB_SEL_I);
	assign wd_sw = wmerge(32'h0000_0000, WB_DAT_I, WB_SEL_I);

	// ==========================================
	// trigger inputs
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			sync1 <= '0;
			sync2 <= '0;
		end
		else
		begin
			sync1 <= TRIG_IN;
			sync2 <= sync1;
		end
	end

	// source 0 is a constant low so an unused event never fires
	assign src = {sync2, 1'b0};

	for (genvar g = 0; g < 4; g++)
	begin : g_edge
		prp_edge u_edge (
			.clk(CLK_SYS),
			.rst_n(RSTN),
			.sig(src[trig_src[4*g+:4]]),
			.mode(prp_pkg::prp_edge_t'(trig_edge[2*g+:2])),
			.evt(hw_evt[g])
		);
	end

	assign ev = hw_evt | sw_cmd;

	// software events are one-cycle pulses
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
			sw_cmd <= '0;
		else if (wr_at(wr, addr, `PRP_OFF_SWEVT))
			sw_cmd <= prp_pkg::prp_evt_t'(wd_sw[3:0]);
		else
			sw_cmd <= '0;
	end

	// ==========================================
	// counter core
	logic running;
	logic mode_ok;
	logic tc;
	logic cc;
	logic swap_now;
	logic killed;
	logic [15:0] lfsr_next;

	assign running = (state == prp_pkg::PRP_RUN);
	assign mode_ok = config_q[`PRP_CFG_MODE_HI:`PRP_CFG_MODE_LO] == `PRP_MODE_PRPWM;
	assign tc = running && (counter == period);
	assign cc = running && (counter == compare);
	assign swap_now = tc && (sw_pending || ev.sw);
	assign lfsr_next = {counter[14:0], counter[15] ^ counter[13] ^ counter[12] ^ counter[10]};
	// sync kill holds through kill_hold, async kill follows the live event
	assign killed = config_q[`PRP_CFG_SYNC_KILL] ? (kill_hold | ev.kill) : ev.kill;

	always_comb
	begin
		next_state = state;
		case (state)
			prp_pkg::PRP_IDLE:
			begin
				if (enabled && mode_ok && (ev.start || ev.reload)
					&& !(ev.kill && config_q[`PRP_CFG_HALT_KILL]))
					next_state = prp_pkg::PRP_RUN;
			end
			prp_pkg::PRP_RUN:
			begin
				if (!enabled || !mode_ok)
					next_state = prp_pkg::PRP_IDLE;
				else if (ev.kill && config_q[`PRP_CFG_HALT_KILL])
					next_state = prp_pkg::PRP_IDLE;
				else if (tc && config_q[`PRP_CFG_ONE_SHOT])
					next_state = prp_pkg::PRP_IDLE;
			end
			default: next_state = prp_pkg::PRP_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
			state <= prp_pkg::PRP_IDLE;
		else
			state <= next_state;
	end

	// software write wins over stepping; an all-zero counter stays zero
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
			counter <= `PRP_RST_WORD16;
		else if (wr_at(wr, addr, `PRP_OFF_COUNTER))
			counter <= wd_cnt[15:0];
		else if (!running && next_state == prp_pkg::PRP_RUN && ev.start && !ev.reload)
			counter <= `PRP_START_SEED;
		else if (running && next_state == prp_pkg::PRP_RUN)
			counter <= lfsr_next;
	end

	// ==========================================
	// switch and kill tracking
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
			sw_pending <= 1'b0;
		else
			sw_pending <= !tc && (sw_pending || ev.sw);
	end

	// a kill in the tc cycle still wins, so the block lasts a full period
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
			kill_hold <= 1'b0;
		else
			kill_hold <= config_q[`PRP_CFG_SYNC_KILL] && (ev.kill || (kill_hold && !tc));
	end

	// ==========================================
	// compare and period pairs
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			compare <= `PRP_RST_WORD16;
			compare_sh <= `PRP_RST_WORD16;
		end
		else if (wr_at(wr, addr, `PRP_OFF_COMPARE))
			compare <= wd_cmp[15:0];
		else if (wr_at(wr, addr, `PRP_OFF_COMPARE_SH))
			compare_sh <= wd_cmps[15:0];
		else if (swap_now && config_q[`PRP_CFG_SWAP_CC])
		begin
			compare <= compare_sh;
			compare_sh <= compare;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			period <= `PRP_RST_WORD16;
			period_sh <= `PRP_RST_WORD16;
		end
		else if (wr_at(wr, addr, `PRP_OFF_PERIOD))
			period <= wd_per[15:0];
		else if (wr_at(wr, addr, `PRP_OFF_PERIOD_SH))
			period_sh <= wd_pers[15:0];
		else if (swap_now && config_q[`PRP_CFG_SWAP_PER])
		begin
			period <= period_sh;
			period_sh <= period;
		end
	end

	// ==========================================
	// configuration registers
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			enabled <= 1'b0;
			config_q <= `PRP_RST_CONFIG;
			trig_src <= `PRP_RST_WORD16;
			trig_edge <= `PRP_RST_TRIG_EDGE;
			out_act <= `PRP_RST_OUT_ACT;
			irq_mask <= 2'h0;
		end
		else
		begin
			if (wr_at(wr, addr, `PRP_OFF_ENABLE))
				enabled <= wmerge({31'h00000000, enabled}, WB_DAT_I, WB_SEL_I) != 32'h0;
			if (wr_at(wr, addr, `PRP_OFF_CONFIG))
				config_q <= wd_cfg;
			if (wr_at(wr, addr, `PRP_OFF_TRIG_SRC))
				trig_src <= wd_src[15:0];
			if (wr_at(wr, addr, `PRP_OFF_TRIG_EDGE))
				trig_edge <= wd_edge[7:0];
			if (wr_at(wr, addr, `PRP_OFF_OUT_ACT))
				out_act <= wd_act[5:0];
			if (wr_at(wr, addr, `PRP_OFF_IRQ_MASK))
				irq_mask <= WB_SEL_I[0] ? WB_DAT_I[1:0] : irq_mask;
		end
	end

	// ==========================================
	// output lines
	logic pwm;
	logic line_val;

	// 16-bit compare against a 15-bit count: 0x8000 and up is always high, 0 never
	assign pwm = {1'b0, counter[14:0]} < compare;

	// wrap events never occur here, so only the match action can alter the line
	always_comb
	begin
		line_val = pwm;
		if (cc)
		begin
			case (prp_pkg::prp_act_t'(out_act[`PRP_ACT_CC_LO+:2]))
				prp_pkg::PRP_SET: line_val = 1'b1;
				prp_pkg::PRP_CLEAR: line_val = 1'b0;
				prp_pkg::PRP_INVERT: line_val = ~pwm;
				default: line_val = pwm;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			LINE_OUT <= 1'b0;
			LINE_OUT_COMPL <= 1'b0;
		end
		else if (!enabled || killed)
		begin
			LINE_OUT <= 1'b0;
			LINE_OUT_COMPL <= 1'b0;
		end
		else
		begin
			LINE_OUT <= line_val;
			LINE_OUT_COMPL <= ~line_val;
		end
	end

	// ==========================================
	// interrupt requests, set wins over clear
	logic [1:0] irq_set;
	logic [1:0] irq_clr;
	logic [1:0] irq_gated;

	// only terminal count, match and the force register can request: no wrap or trigger events exist
	assign irq_set = {cc, tc}
		| ((wr_at(wr, addr, `PRP_OFF_IRQ_FORCE) && WB_SEL_I[0]) ? WB_DAT_I[1:0] : 2'h0);
	assign irq_clr = (wr_at(wr, addr, `PRP_OFF_IRQ_REQ) && WB_SEL_I[0]) ? WB_DAT_I[1:0] : 2'h0;
	assign irq_gated = irq_req & irq_mask;

	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			irq_req <= 2'h0;
			IRQ_OUT <= 1'b0;
		end
		else
		begin
			irq_req <= (irq_req & ~irq_clr) | irq_set;
			IRQ_OUT <= |irq_gated;
		end
	end

	// ==========================================
	// read mux and acknowledge
	always_comb
	begin
		case (addr)
			`PRP_OFF_ENABLE: rdata = {31'h00000000, enabled};
			`PRP_OFF_SOURCE: rdata = {31'h00000000, |irq_gated};
			`PRP_OFF_CONFIG: rdata = config_q;
			`PRP_OFF_STATUS: rdata = {29'h00000000, kill_hold, sw_pending, running};
			`PRP_OFF_COUNTER: rdata = {16'h0000, counter};
			`PRP_OFF_COMPARE: rdata = {16'h0000, compare};
			`PRP_OFF_COMPARE_SH: rdata = {16'h0000, compare_sh};
			`PRP_OFF_PERIOD: rdata = {16'h0000, period};
			`PRP_OFF_PERIOD_SH: rdata = {16'h0000, period_sh};
			`PRP_OFF_TRIG_SRC: rdata = {16'h0000, trig_src};
			`PRP_OFF_TRIG_EDGE: rdata = {24'h000000, trig_edge};
			`PRP_OFF_OUT_ACT: rdata = {26'h0000000, out_act};
			`PRP_OFF_IRQ_REQ: rdata = {30'h00000000, irq_req};
			`PRP_OFF_IRQ_FORCE: rdata = {30'h00000000, irq_req};
			`PRP_OFF_IRQ_MASK: rdata = {30'h00000000, irq_mask};
			`PRP_OFF_IRQ_GATED: rdata = {30'h00000000, irq_gated};
			default: rdata = 32'h0000_0000;
		endcase
	end

	// one wait state; ack drops the cycle after it is given
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end
		else
		begin
			WB_ACK_O <= req && !WB_ACK_O;
			if (req && !WB_ACK_O)
				WB_DAT_O <= rdata;
		end
	end
endmodule

/* File: bench/prp_top_asserts.sv */
// Purpose: port-level checks of the pseudo-random pwm channel
// Assumes: one clock, ack one cycle after the taken request
// Notes: counter timing is judged by the bench through the registers
`include "prp_cfg.svh"
module prp_top_asserts (
	input wire logic CLK_SYS,
	input wire logic RSTN,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:2] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	input wire logic [`PRP_NTRIG-1:0] TRIG_IN,
	input wire logic LINE_OUT,
	input wire logic LINE_OUT_COMPL,
	input wire logic IRQ_OUT
);
	// ==========================================
	// bus and output relations
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RSTN);
	logic rd_ack;
	assign rd_ack = WB_ACK_O && !WB_WE_I;
	chk_ack_answer: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
		else $error("request not answered next cycle");
	chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held two cycles");
	chk_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
		else $error("ack without request");
	chk_unmapped_zero: assert property ((rd_ack && WB_ADR_I > 6'h10) |-> WB_DAT_O == 32'h0)
		else $error("unmapped read not zero");
	chk_config_bits: assert property ((rd_ack && WB_ADR_I == 6'h03) |->
		(WB_DAT_O & ~`PRP_CFG_MASK) == 32'h0) else $error("config spare bits set");
	chk_word16_upper: assert property ((rd_ack && WB_ADR_I inside {[6'h05:6'h09]}) |->
		WB_DAT_O[31:16] == 16'h0) else $error("16-bit register upper half set");
	chk_gated_irq: assert property ((rd_ack && WB_ADR_I == 6'h10) |->
		WB_DAT_O[31:2] == 30'h0 && IRQ_OUT == |WB_DAT_O[1:0]) else $error("gated view off");
	chk_source_irq: assert property ((rd_ack && WB_ADR_I == 6'h02) |->
		WB_DAT_O == {31'h0, IRQ_OUT}) else $error("source bit differs from irq line");
	chk_compl_excl: assert property (LINE_OUT |-> !LINE_OUT_COMPL)
		else $error("both lines high");
	chk_reset_quiet: assert property ($rose(RSTN) |-> !LINE_OUT && !IRQ_OUT && !WB_ACK_O)
		else $error("output active after reset");
	cov_write: cover property (WB_ACK_O && WB_WE_I);
	cov_line: cover property ($rose(LINE_OUT));
	cov_irq: cover property ($rose(IRQ_OUT));
endmodule
bind prp_top prp_top_asserts u_prp_top_asserts (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
	.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
	.WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
	.TRIG_IN(TRIG_IN), .LINE_OUT(LINE_OUT), .LINE_OUT_COMPL(LINE_OUT_COMPL), .IRQ_OUT(IRQ_OUT));

/* File: bench/prp_trig_src.sv */
// Purpose: on-chip trigger source feeding the channel's trigger pins
// Assumes: pins idle low, one pin pulses per request
// Notes: four-cycle pulse so the two-flop synchroniser cannot miss it
module prp_trig_src (
	input wire logic clk,
	input wire logic fire,
	input wire logic [3:0] idx,
	output logic [14:0] pins
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// pulse on the selected source index
	logic [2:0] cnt = 3'h0;
	always_ff @(posedge clk)
	begin
		if (fire)
			cnt <= 3'h4;
		else if (cnt != 3'h0)
			cnt <= cnt - 3'h1;
	end
	assign pins = (cnt != 3'h0) ? (15'h1 << (idx - 4'h1)) : 15'h0;
endmodule

/* File: bench/tb_pseudo_random_pwm.sv */
// Purpose: self-checking bench of the pseudo-random pwm channel
// Assumes: wishbone answer one cycle after the request, start seeds 0x0001
// Notes: lfsr expectations come from the bench's own step function
`include "prp_cfg.svh"
module tb_pseudo_random_pwm;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] MODE = 32'h0600_0000;
	logic clk_sys, rstn, cyc, stb, we, fire, line, compl, irq, ack;
	logic [5:0] adr;
	logic [3:0] sel, idx;
	logic [31:0] dat_i, dat_o, q;
	logic [14:0] trig;
	logic [15:0] sd, per;
	logic [15:0] lim [3] = '{16'h0, 16'h8000, 16'hffff};
	int seed, mismatches, samples_checked, n;
	prp_top u_prp_top (.CLK_SYS(clk_sys), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
		.WB_ACK_O(ack), .TRIG_IN(trig), .LINE_OUT(line), .LINE_OUT_COMPL(compl), .IRQ_OUT(irq));
	prp_trig_src u_prp_trig_src (.clk(clk_sys), .fire(fire), .idx(idx), .pins(trig));
	// ==========================================
	// clock, helpers
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	function automatic logic [15:0] step(input logic [15:0] v, input int k);
		for (int i = 0; i < k; i++)
			v = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
		return v;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a[7:2];
		dat_i <= d;
		// ack is looked at mid-cycle, then the request is held to the edge that takes it
		do
		begin
			@(negedge clk_sys);
			t++;
		end
		while (ack !== 1'b1 && t < 20);
		q = dat_o;
		@(posedge clk_sys);
		cyc <= 1'b0;
		stb <= 1'b0;
		if (t >= 20)
		begin
			mismatches++;
			$display("FAIL %0t bus timeout", $time);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q & m, e);
	endtask
	task automatic cfg(input logic [15:0] c0, input logic [15:0] p, input logic [15:0] c,
		input logic [31:0] w);
		wb(1'b1, `PRP_OFF_ENABLE, 32'h0);
		wb(1'b1, `PRP_OFF_CONFIG, w);
		wb(1'b1, `PRP_OFF_COUNTER, {16'h0, c0});
		wb(1'b1, `PRP_OFF_PERIOD, {16'h0, p});
		wb(1'b1, `PRP_OFF_COMPARE, {16'h0, c});
		wb(1'b1, `PRP_OFF_ENABLE, 32'h1);
	endtask
	task automatic wait_idle();
		int t;
		t = 0;
		do
		begin
			wb(1'b0, `PRP_OFF_STATUS, 32'h0);
			t++;
		end
		while (q[0] !== 1'b0 && t < 300);
		if (t >= 300)
		begin
			mismatches++;
			$display("FAIL %0t channel never stopped", $time);
		end
	endtask
	task print_verdict;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ==========================================
	// tests
	initial
	begin
		seed = 4218;
		mismatches = 0;
		samples_checked = 0;
		{rstn, cyc, stb, we, fire, adr, dat_i} = '0;
		sel = 4'hf;
		idx = 4'h3;
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		rd(`PRP_OFF_OUT_ACT, 32'hffff_ffff, 32'h3f);
		rd(`PRP_OFF_CONFIG, 32'hffff_ffff, 32'h0);
		rd(8'h44, 32'hffff_ffff, 32'h0);
		$display("done reset values");
		cfg(16'h1, 16'h1234, 16'h0, 32'h0400_0004);
		wb(1'b1, `PRP_OFF_SWEVT, 32'h2);
		rd(`PRP_OFF_STATUS, 32'h1, 32'h0);
		$display("done mode decode");
		repeat (4)
		begin
			sd = 16'($random(seed)) | 16'h1;
			n = 5 + ($random(seed) & 31);
			per = step(sd, n);
			cfg(sd, per, 16'($random(seed)), MODE | 32'h4);
			wb(1'b1, `PRP_OFF_SWEVT, 32'h1);
			wait_idle();
			rd(`PRP_OFF_COUNTER, 32'hffff, {16'h0, per});
			rd(`PRP_OFF_IRQ_REQ, 32'h1, 32'h1);
			wb(1'b1, `PRP_OFF_IRQ_REQ, 32'h3);
		end
		cfg(16'h1234, step(16'h1, 20), 16'h0, MODE | 32'h4);
		wb(1'b1, `PRP_OFF_SWEVT, 32'h2);
		wait_idle();
		rd(`PRP_OFF_COUNTER, 32'hffff, {16'h0, step(16'h1, 20)});
		$display("done one-shot runs");
		for (int i = 0; i < 3; i++)
		begin
			cfg(16'h1, step(16'h1, 80), lim[i], MODE | 32'h4);
			wb(1'b1, `PRP_OFF_SWEVT, 32'h2);
			repeat (4) @(posedge clk_sys);
			repeat (40)
			begin
				@(negedge clk_sys);
				chk({line, compl}, {lim[i] != 16'h0, lim[i] == 16'h0});
			end
			wait_idle();
		end
		$display("done duty limits");
		wb(1'b1, `PRP_OFF_ENABLE, 32'h0);
		wb(1'b1, `PRP_OFF_TRIG_SRC, 32'h3000);
		wb(1'b1, `PRP_OFF_COMPARE_SH, 32'h0456);
		cfg(16'h1, step(16'h1, 60), 16'h0123, MODE | 32'h5);
		wb(1'b1, `PRP_OFF_SWEVT, 32'h2);
		@(posedge clk_sys);
		fire <= 1'b1;
		@(posedge clk_sys);
		fire <= 1'b0;
		wait_idle();
		rd(`PRP_OFF_COMPARE, 32'hffff, 32'h0456);
		rd(`PRP_OFF_COMPARE_SH, 32'hffff, 32'h0123);
		$display("done switch swap");
		cfg(16'h1, step(16'h1, 3000), 16'h0, MODE | 32'h8);
		wb(1'b1, `PRP_OFF_SWEVT, 32'h2);
		wb(1'b1, `PRP_OFF_SWEVT, 32'h4);
		wait_idle();
		rd(`PRP_OFF_STATUS, 32'h1, 32'h0);
		$display("done halting kill");
		wb(1'b1, `PRP_OFF_IRQ_REQ, 32'h3);
		wb(1'b1, `PRP_OFF_IRQ_MASK, 32'h1);
		wb(1'b1, `PRP_OFF_IRQ_FORCE, 32'h3);
		rd(`PRP_OFF_IRQ_REQ, 32'h3, 32'h3);
		rd(`PRP_OFF_IRQ_GATED, 32'h3, 32'h1);
		rd(`PRP_OFF_SOURCE, 32'h1, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wb(1'b1, `PRP_OFF_IRQ_REQ, 32'h3);
		rd(`PRP_OFF_IRQ_REQ, 32'h3, 32'h0);
		$display("done interrupt bits");
		print_verdict();
	end
	// a hang is cut short at 40000 cycles, well past the expected run of about a thousand cycles
	initial
	begin
		#400000;
		mismatches++;
		$display("FAIL %0t watchdog expired", $time);
		print_verdict();
	end
endmodule
